// ===== logic/csm_pkg.sv
package csm_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PRIO = 8'h04;
  localparam logic [7:0] ADR_PINFN = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [7:0] ADR_ENC1 = 8'h10;
  localparam logic [7:0] ADR_ENC2 = 8'h14;

  // Control register fields.
  localparam int CTRL_SSI = 0;
  localparam int CTRL_MENC = 1;
  localparam int CTRL_ILK = 2;
  localparam int CTRL_FW_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h24;
  localparam logic [3:0] FW_V2 = 4'h2;

  // Status register fields.
  localparam int STAT_ARMED = 2;
  localparam int STAT_FAULT = 3;
  localparam int STAT_USB = 4;
  localparam int STAT_PWR = 5;

  // Command sources and the pin functions.
  typedef enum logic [1:0] {
    SRC_NONE, SRC_SERIAL, SRC_PULSE, SRC_ANALOG
  } csm_src_t;
  typedef enum logic [1:0] {
    FN_OFF, FN_PULSE, FN_ANALOG, FN_DIGITAL
  } csm_fn_t;

  // Slot 1 serial, slot 2 pulse, slot 3 none; analog stays out.
  localparam logic [5:0] PRIO_RST = 6'h09;
  // Pins 0 and 1 pulse, pins 2 and 3 analog, the rest off.
  localparam logic [15:0] PINFN_RST = 16'h00A5;
  localparam int NPIN = 8;
  localparam int STO_PIN_A = 2;
  localparam int STO_PIN_B = 3;
  localparam int ENC2_PIN = 4;
  localparam int ENC1_PIN = 6;

  // Analog window in millivolts.
  localparam logic [12:0] ANA_MIN_MV = 13'h00FA;
  localparam logic [12:0] ANA_MAX_MV = 13'h128E;
  localparam logic [12:0] ANA_CTR_LO_MV = 13'h0960;
  localparam logic [12:0] ANA_CTR_HI_MV = 13'h0A28;

  // Link clock and the least idle pause between encoder frames.
  localparam int LCLK_NS = 80;
  localparam int PAUSE_NS = 20000;
  localparam int PAUSE_CYC = (PAUSE_NS + LCLK_NS - 1) / LCLK_NS;

endpackage

// ===== logic/csm_ssi_rd.sv
`timescale 1ns/100ps
module csm_ssi_rd
  import csm_pkg::*;
#(
  parameter int BITS = 16,
  parameter int PAUSE = PAUSE_CYC
) (
  input wire logic lclk,
  input wire logic lrst_n,
  input wire logic en,
  input wire logic data_p,
  input wire logic data_n,
  output logic sclk,
  output logic [BITS-1:0] word,
  output logic done_tgl
);

  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_WAIT} csm_ssi_st_t;

  csm_ssi_st_t st_ff, nxt_st;
  logic [BITS-1:0] sr_ff, nxt_sr, word_ff, nxt_word;
  logic [4:0] bit_ff, nxt_bit;
  logic [15:0] gap_ff, nxt_gap;
  logic sclk_ff, nxt_sclk, tgl_ff, nxt_tgl;
  logic p1_ff, p2_ff, n1_ff, n2_ff;
  logic din;

  // The pair is read through two flops each before any decision.
  always_ff @(posedge lclk) begin
    p1_ff <= data_p;
    p2_ff <= p1_ff;
    n1_ff <= data_n;
    n2_ff <= n1_ff;
  end

  // A one is seen only when the pair really says so.
  assign din = p2_ff & ~n2_ff;

  // Frame sequencer: idle high, one bit per clock period, msb first.
  always_comb begin
    nxt_st = st_ff;
    nxt_sr = sr_ff;
    nxt_word = word_ff;
    nxt_bit = bit_ff;
    nxt_gap = gap_ff;
    nxt_sclk = 1'b1;
    nxt_tgl = tgl_ff;
    unique case (st_ff)
      S_IDLE: begin
        nxt_bit = 5'h00;
        if (en) begin
          nxt_st = S_LOW;
          nxt_sclk = 1'b0;
        end
      end
      S_LOW: begin
        nxt_st = S_HIGH;
      end
      S_HIGH: begin
        nxt_sr = {sr_ff[BITS-2:0], din};
        nxt_bit = 5'(bit_ff + 5'h01);
        if (bit_ff == 5'(BITS - 1)) begin
          nxt_st = S_WAIT;
          nxt_gap = 16'h0000;
        end else begin
          nxt_st = S_LOW;
          nxt_sclk = 1'b0;
        end
      end
      S_WAIT: begin
        // The line must be back to idle and quiet for the whole pause.
        if (!din) begin
          nxt_gap = 16'h0000;
        end else begin
          nxt_gap = 16'(gap_ff + 16'h0001);
        end
        if (din && gap_ff >= 16'(PAUSE - 1)) begin
          nxt_st = S_IDLE;
          nxt_word = sr_ff;
          nxt_tgl = ~tgl_ff;
        end
      end
    endcase
  end

  // Link-side state registers.
  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      st_ff <= S_IDLE;
      sr_ff <= '0;
      word_ff <= '0;
      bit_ff <= 5'h00;
      gap_ff <= 16'h0000;
      sclk_ff <= 1'b1;
      tgl_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sr_ff <= nxt_sr;
      word_ff <= nxt_word;
      bit_ff <= nxt_bit;
      gap_ff <= nxt_gap;
      sclk_ff <= nxt_sclk;
      tgl_ff <= nxt_tgl;
    end
  end

  assign sclk = sclk_ff;
  assign word = word_ff;
  assign done_tgl = tgl_ff;

endmodule

// ===== logic/csm_top.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
module csm_top
  import csm_pkg::*;
#(
  parameter int ENC_BITS = 16,
  parameter int PAUSE = PAUSE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic lclk,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic c1_pin2,
  input wire logic c1_pin3,
  input wire logic c1_pin4_in,
  output logic c1_pin4_out,
  output logic c1_pin4_oe_n,
  output logic c1_pin5_out,
  output logic c1_pin5_oe_n,
  input wire logic c2_pin2,
  input wire logic c2_pin3,
  input wire logic c2_pin4_in,
  output logic c2_pin4_out,
  output logic c2_pin4_oe_n,
  output logic c2_pin5_out,
  output logic c2_pin5_oe_n,
  input wire logic [7:0] main_pin,
  output logic encoder_one_phase_a,
  output logic encoder_one_phase_b,
  output logic encoder_two_phase_a,
  output logic encoder_two_phase_b,
  output logic encoder_three_phase_a,
  output logic encoder_three_phase_b,
  output logic [7:0] pulse_in,
  output logic [7:0] digital_in,
  output logic [7:0] analog_en,
  output logic torque_off_input_a,
  output logic torque_off_input_b,
  input wire logic sto_jumper,
  output logic power_enable,
  input wire logic serial_valid,
  input wire logic pulse_valid,
  input wire logic analog_valid,
  input wire logic [12:0] analog_mv,
  output logic [1:0] cmd_source,
  output logic cmd_allow,
  input wire logic usb_present,
  output logic usb_link_ok,
  output logic can_enable,
  input wire logic rs485_tx_active,
  output logic rs485_drv_oe_n,
  output logic rs485_rcv_en_n
);

  if (ENC_BITS < 2 || ENC_BITS > 16) begin : g_bits_chk
    $error("ENC_BITS must lie between 2 and 16");
  end
  if (PAUSE < 1 || PAUSE > 65535) begin : g_pause_chk
    $error("PAUSE must lie between 1 and 65535");
  end

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [5:0] prio_ff, nxt_prio;
  logic [15:0] pinfn_ff, nxt_pinfn;
  logic fault_ff, nxt_fault;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [ENC_BITS-1:0] enc1_ff, nxt_enc1, enc2_ff, nxt_enc2;
  logic [7:0] mp1_ff, mp2_ff;
  logic [5:0] cp1_ff, cp2_ff;
  logic sj1_ff, sj2_ff, up1_ff, up2_ff, up3_ff;
  logic [2:0] t1_ff, t2_ff;
  logic ssi_on, menc_on, ilk_on, fw_v2, sto_on, req;
  logic [31:0] rd_val;
  logic [1:0] src_ff, nxt_src;
  logic armed_ff, nxt_armed, lost_ff, nxt_lost;

  // Slow pins and straps pass two flops before any logic reads them.
  always_ff @(posedge mclk) begin
    mp1_ff <= main_pin;
    mp2_ff <= mp1_ff;
    cp1_ff <= {c2_pin4_in, c2_pin3, c2_pin2, c1_pin4_in, c1_pin3, c1_pin2};
    cp2_ff <= cp1_ff;
    sj1_ff <= sto_jumper;
    sj2_ff <= sj1_ff;
    up1_ff <= usb_present;
    up2_ff <= up1_ff;
    up3_ff <= up2_ff;
  end

  assign ssi_on = ctrl_ff[CTRL_SSI];
  assign fw_v2 = ctrl_ff[CTRL_FW_LSB+3:CTRL_FW_LSB] >= FW_V2;
  assign menc_on = ssi_on && fw_v2 && ctrl_ff[CTRL_MENC];
  assign ilk_on = ctrl_ff[CTRL_ILK];
  assign sto_on = sj2_ff;
  assign req = wb_cyc_i && wb_stb_i;

  // ---- Link domain: encoder readers and the connector clock pins. ----
  logic lr1_ff, lr2_ff, le1_ff, le2_ff;
  logic sclk1, sclk2, tgl1, tgl2;
  logic [ENC_BITS-1:0] word1, word2;

  // Reset and the absolute-mode enable cross into the link domain.
  always_ff @(posedge lclk) begin
    lr1_ff <= rst_n;
    lr2_ff <= lr1_ff;
    le1_ff <= ssi_on;
    le2_ff <= le1_ff;
  end

  // One reader per encoder, each on its own data pair.
  csm_ssi_rd #(.BITS(ENC_BITS), .PAUSE(PAUSE)) u_rd1 (
    .lclk(lclk),
    .lrst_n(lr2_ff),
    .en(le2_ff),
    .data_p(c1_pin2),
    .data_n(c1_pin3),
    .sclk(sclk1),
    .word(word1),
    .done_tgl(tgl1)
  );
  csm_ssi_rd #(.BITS(ENC_BITS), .PAUSE(PAUSE)) u_rd2 (
    .lclk(lclk),
    .lrst_n(lr2_ff),
    .en(le2_ff),
    .data_p(c2_pin2),
    .data_n(c2_pin3),
    .sclk(sclk2),
    .word(word2),
    .done_tgl(tgl2)
  );

  // Pins 4 and 5 carry the clock pair only while absolute mode is on.
  assign c1_pin4_out = ~sclk1;
  assign c1_pin5_out = sclk1;
  assign c2_pin4_out = ~sclk2;
  assign c2_pin5_out = sclk2;
  assign c1_pin4_oe_n = ~le2_ff;
  assign c1_pin5_oe_n = ~le2_ff;
  assign c2_pin4_oe_n = ~le2_ff;
  assign c2_pin5_oe_n = ~le2_ff;

  // Frame-done toggles cross back; words are stable for a whole frame.
  always_ff @(posedge mclk) begin
    t1_ff <= {t1_ff[1:0], tgl1};
    t2_ff <= {t2_ff[1:0], tgl2};
  end

  // ---- Register file on the Wishbone slave. ----
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Read value of the addressed word; unmapped words read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_CTRL: rd_val = {24'h00_0000, ctrl_ff};
      ADR_PRIO: rd_val = {26'h000_0000, prio_ff};
      ADR_PINFN: rd_val = {16'h0000, pinfn_ff};
      ADR_STAT: rd_val = {26'h000_0000, power_enable, usb_link_ok,
                          fault_ff, armed_ff, src_ff};
      ADR_ENC1: rd_val = 32'(enc1_ff);
      ADR_ENC2: rd_val = 32'(enc2_ff);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Data is latched when a request opens, acked one cycle later, and a
  // write lands on the edge that sees ack high.
  always_comb begin
    logic wr;
    logic [31:0] m;
    wr = req && wb_we_i && ack_ff;
    m = 32'h0000_0000;
    nxt_ack = req && !ack_ff;
    nxt_dat = (req && !ack_ff) ? rd_val : dat_ff;
    nxt_ctrl = ctrl_ff;
    nxt_prio = prio_ff;
    nxt_pinfn = pinfn_ff;
    nxt_enc1 = (t1_ff[2] != t1_ff[1]) ? word1 : enc1_ff;
    nxt_enc2 = (t2_ff[2] != t2_ff[1]) ? word2 : enc2_ff;
    // A mismatched torque-off pair sets the fault; set beats clear.
    nxt_fault = fault_ff;
    if (wr && wb_adr_i == ADR_STAT && wb_sel_i[0] &&
        wb_dat_i[STAT_FAULT]) begin
      nxt_fault = 1'b0;
    end
    if (sto_on && (mp2_ff[STO_PIN_A] != mp2_ff[STO_PIN_B])) begin
      nxt_fault = 1'b1;
    end
    if (wr) begin
      unique case (wb_adr_i)
        ADR_CTRL: begin
          m = merge({24'h00_0000, ctrl_ff}, wb_dat_i, wb_sel_i);
          nxt_ctrl = m[7:0];
        end
        ADR_PRIO: begin
          m = merge({26'h000_0000, prio_ff}, wb_dat_i, wb_sel_i);
          nxt_prio = m[5:0];
        end
        ADR_PINFN: begin
          m = merge({16'h0000, pinfn_ff}, wb_dat_i, wb_sel_i);
          nxt_pinfn = m[15:0];
        end
        default: m = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops; analog is absent from the reset order.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      ctrl_ff <= CTRL_RST;
      prio_ff <= PRIO_RST;
      pinfn_ff <= PINFN_RST;
      fault_ff <= 1'b0;
      enc1_ff <= '0;
      enc2_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ctrl_ff <= nxt_ctrl;
      prio_ff <= nxt_prio;
      pinfn_ff <= nxt_pinfn;
      fault_ff <= nxt_fault;
      enc1_ff <= nxt_enc1;
      enc2_ff <= nxt_enc2;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ---- Pin routing. ----
  logic [5:0] enc_ff, nxt_enc;
  logic [7:0] pls_ff, nxt_pls, din_ff, nxt_din, ana_ff, nxt_ana;
  logic [1:0] sto_ff, nxt_sto;

  // Each shared pin feeds only the function its two select bits name.
  always_comb begin
    csm_fn_t fn;
    fn = FN_OFF;
    nxt_pls = 8'h00;
    nxt_din = 8'h00;
    nxt_ana = 8'h00;
    for (int i = 0; i < NPIN; i++) begin
      fn = csm_fn_t'(pinfn_ff[i*2 +: 2]);
      if (!(menc_on && i >= ENC2_PIN) &&
          !(sto_on && (i == STO_PIN_A || i == STO_PIN_B))) begin
        nxt_pls[i] = (fn == FN_PULSE) && mp2_ff[i];
        nxt_din[i] = (fn == FN_DIGITAL) && mp2_ff[i];
        nxt_ana[i] = (fn == FN_ANALOG);
      end
    end
    nxt_sto = sto_on ? {mp2_ff[STO_PIN_B], mp2_ff[STO_PIN_A]} : 2'b00;
    // Encoder phases: {3b, 3a, 2b, 2a, 1b, 1a}.
    if (!ssi_on) begin
      nxt_enc = {cp2_ff[5], cp2_ff[2], cp2_ff[4:3], cp2_ff[1:0]};
    end else if (menc_on) begin
      nxt_enc = {2'b00, mp2_ff[ENC2_PIN +: 2], mp2_ff[ENC1_PIN +: 2]};
    end else begin
      nxt_enc = 6'h00;
    end
  end

  // Routed pin outputs come from flops.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enc_ff <= 6'h00;
      pls_ff <= 8'h00;
      din_ff <= 8'h00;
      ana_ff <= 8'h00;
      sto_ff <= 2'b00;
    end else begin
      enc_ff <= nxt_enc;
      pls_ff <= nxt_pls;
      din_ff <= nxt_din;
      ana_ff <= nxt_ana;
      sto_ff <= nxt_sto;
    end
  end

  assign encoder_one_phase_a = enc_ff[0];
  assign encoder_one_phase_b = enc_ff[1];
  assign encoder_two_phase_a = enc_ff[2];
  assign encoder_two_phase_b = enc_ff[3];
  assign encoder_three_phase_a = enc_ff[4];
  assign encoder_three_phase_b = enc_ff[5];
  assign pulse_in = pls_ff;
  assign digital_in = din_ff;
  assign analog_en = ana_ff;
  assign torque_off_input_a = sto_ff[0];
  assign torque_off_input_b = sto_ff[1];
  // Without the torque-off option the power stage is never held here.
  assign power_enable = !sto_on || (sto_ff == 2'b11);

  // ---- Command arbitration, analog interlock and the USB latch. ----
  logic in_rng, centered;

  assign in_rng = analog_mv >= ANA_MIN_MV && analog_mv <= ANA_MAX_MV;
  assign centered = analog_mv >= ANA_CTR_LO_MV &&
                    analog_mv <= ANA_CTR_HI_MV;

  // Slots are walked in order; the first valid one takes control.
  always_comb begin
    csm_src_t s;
    logic found;
    s = SRC_NONE;
    found = 1'b0;
    nxt_src = 2'(SRC_NONE);
    for (int k = 0; k < 3; k++) begin
      s = csm_src_t'(prio_ff[k*2 +: 2]);
      if (!found && ((s == SRC_SERIAL && serial_valid) ||
                     (s == SRC_PULSE && pulse_valid) ||
                     (s == SRC_ANALOG && analog_valid))) begin
        nxt_src = 2'(s);
        found = 1'b1;
      end
    end
    // Old firmware keeps pulse commands live as a last resort.
    if (!found && !fw_v2 && pulse_valid) begin
      nxt_src = 2'(SRC_PULSE);
    end
    // Arming needs a centered stick; it drops on leaving the analog
    // source or the valid window, so every new start re-centers.
    nxt_armed = armed_ff;
    if (!ilk_on) begin
      nxt_armed = 1'b1;
    end else if (!in_rng || nxt_src != 2'(SRC_ANALOG)) begin
      nxt_armed = 1'b0;
    end else if (centered) begin
      nxt_armed = 1'b1;
    end
    // Once the host drops off, the link is not brought back.
    nxt_lost = lost_ff || (up3_ff && !up2_ff);
  end

  // Arbitration state flops.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_ff <= 2'(SRC_NONE);
      armed_ff <= 1'b0;
      lost_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      armed_ff <= nxt_armed;
      lost_ff <= nxt_lost;
    end
  end

  assign cmd_source = src_ff;
  assign cmd_allow = (src_ff != 2'(SRC_NONE)) &&
                     (src_ff != 2'(SRC_ANALOG) || armed_ff);
  assign usb_link_ok = up2_ff && !lost_ff;
  // CAN stays up whatever the USB side does.
  assign can_enable = 1'b1;
  // One pair: the receiver is shut while the driver talks.
  assign rs485_drv_oe_n = ~rs485_tx_active;
  assign rs485_rcv_en_n = rs485_tx_active;

endmodule

// ===== verification/csm_chk_sva.sv
`timescale 1ns/100ps
module csm_chk
  import csm_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic lclk,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic c1_pin4_out,
  input logic c1_pin4_oe_n,
  input logic c1_pin5_out,
  input logic c1_pin5_oe_n,
  input logic [7:0] pulse_in,
  input logic [7:0] digital_in,
  input logic [7:0] analog_en,
  input logic torque_off_input_a,
  input logic torque_off_input_b,
  input logic power_enable,
  input logic [1:0] cmd_source,
  input logic cmd_allow,
  input logic can_enable,
  input logic rs485_tx_active,
  input logic rs485_drv_oe_n,
  input logic rs485_rcv_en_n
);
  // Bus, arbitration and pin checks run on the system clock.
  property p_ack;
    @(posedge mclk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  property p_can;
    @(posedge mclk) disable iff (!rst_n) can_enable;
  endproperty
  a_can: assert property (p_can) else $error("can disabled");
  property p_half;
    @(posedge mclk) disable iff (!rst_n)
    rs485_drv_oe_n == !rs485_tx_active && rs485_rcv_en_n == rs485_tx_active;
  endproperty
  a_half: assert property (p_half) else $error("port not half duplex");
  property p_power;
    @(posedge mclk) disable iff (!rst_n)
    torque_off_input_a || torque_off_input_b |->
      power_enable == (torque_off_input_a && torque_off_input_b);
  endproperty
  a_power: assert property (p_power) else $error("power wrong");
  property p_allow;
    @(posedge mclk) disable iff (!rst_n) cmd_allow |-> cmd_source != SRC_NONE;
  endproperty
  a_allow: assert property (p_allow) else $error("allow with no source");
  property p_excl;
    @(posedge mclk) disable iff (!rst_n)
    (pulse_in & digital_in) == 8'h00 && (analog_en & pulse_in) == 8'h00;
  endproperty
  a_excl: assert property (p_excl) else $error("pin has two functions");
  property p_sto;
    @(posedge mclk) disable iff (!rst_n)
    torque_off_input_a |-> !digital_in[STO_PIN_A];
  endproperty
  a_sto: assert property (p_sto) else $error("pin kept digital use");
  // Encoder clock checks run on the link clock.
  property p_diff;
    @(posedge lclk) disable iff (!rst_n)
    !c1_pin5_oe_n |-> c1_pin4_out != c1_pin5_out && !c1_pin4_oe_n;
  endproperty
  a_diff: assert property (p_diff) else $error("clock not differential");
  property p_low;
    @(posedge lclk) disable iff (!rst_n)
    !c1_pin5_oe_n && !c1_pin5_out |=> c1_pin5_out;
  endproperty
  a_low: assert property (p_low) else $error("clock low too long");
endmodule
bind csm_top csm_chk chk (.*);

// ===== verification/csm_enc_model.sv
`timescale 1ns/100ps
module csm_enc_model #(
  parameter int BITS = 16
) (
  input logic lclk,
  input logic clk_p,
  input logic oe_n,
  input logic [BITS-1:0] word,
  output logic data_p,
  output logic data_n
);
  int idx = 0;
  int hi = 0;
  logic prev = 1'h1;
  // A bit changes as the clock falls, so it has crossed the reader's two
  // flops by the end of the next high half; a long high clock ends the frame.
  // Changing on the rise instead would repeat the first bit.
  always @(posedge lclk) begin
    prev <= clk_p;
    hi <= clk_p ? hi + 1 : 0;
    if (oe_n || (clk_p && hi >= 3))
      idx <= 0;
    else if (prev && !clk_p && idx < BITS)
      idx <= idx + 1;
  end
  // After the last bit the line rests high, as the pull-up would hold it.
  always_comb begin
    data_p = (idx < BITS) ? word[BITS-1-idx] : 1'h1;
    data_n = ~data_p;
  end
endmodule

// ===== verification/test_csm_top.sv
`timescale 1ns/100ps
module test_csm_top
  import csm_pkg::*;
;
  logic mclk, rst_n, lclk, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, main_pin, pulse_in, digital_in, analog_en;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic c1_pin2, c1_pin3, c1_pin4_in, c1_pin4_out, c1_pin4_oe_n;
  logic c1_pin5_out, c1_pin5_oe_n, c2_pin2, c2_pin3, c2_pin4_in;
  logic c2_pin4_out, c2_pin4_oe_n, c2_pin5_out, c2_pin5_oe_n;
  logic encoder_one_phase_a, encoder_one_phase_b, encoder_two_phase_a;
  logic encoder_two_phase_b, encoder_three_phase_a, encoder_three_phase_b;
  logic torque_off_input_a, torque_off_input_b, sto_jumper, power_enable;
  logic serial_valid, pulse_valid, analog_valid, cmd_allow, usb_present;
  logic usb_link_ok, can_enable, rs485_tx_active, rs485_drv_oe_n;
  logic rs485_rcv_en_n, q1a, q1b, q2a, d1p, d1n, d2p, d2n;
  logic [12:0] analog_mv;
  logic [1:0] cmd_source;
  logic [15:0] w1, w2;
  int n_errors, checked, tick;

  // Quadrature levels in incremental mode, encoder data once clocked.
  assign c1_pin2 = c1_pin4_oe_n ? q1a : d1p;
  assign c1_pin3 = c1_pin4_oe_n ? q1b : d1n;
  assign c2_pin2 = c2_pin4_oe_n ? q2a : d2p;
  assign c2_pin3 = c2_pin4_oe_n ? ~q2a : d2n;
  assign c1_pin4_in = q2a;
  assign c2_pin4_in = q1a;

  csm_top #(.ENC_BITS(16), .PAUSE(4)) dut (.*);
  csm_enc_model m1 (.lclk(lclk), .clk_p(c1_pin5_out), .oe_n(c1_pin5_oe_n),
    .word(w1), .data_p(d1p), .data_n(d1n));
  csm_enc_model m2 (.lclk(lclk), .clk_p(c2_pin5_out), .oe_n(c2_pin5_oe_n),
    .word(w2), .data_p(d2p), .data_n(d2n));

  // The link clock is offset so its edges never line up with mclk.
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    lclk = 1'h0;
    #7.3;
    forever #40 lclk = ~lclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // One classic cycle; the request holds until ack is seen.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input string s, input logic [7:0] a,
                       input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(s, e, rd);
  endtask

  task automatic t_reset;
    rdchk("ctrl", ADR_CTRL, 32'h24);
    rdchk("prio", ADR_PRIO, 32'h09);
    rdchk("pinfn", ADR_PINFN, 32'hA5);
    rdchk("stat", ADR_STAT, 32'h20);
    wb(1'h1, ADR_ENC1, 32'hFFFF);
    rdchk("enc1", ADR_ENC1, 32'h0);
    rdchk("hole", 8'h20, 32'h0);
  endtask
  task automatic t_arb;
    serial_valid <= 1'h1;
    pulse_valid <= 1'h1;
    analog_valid <= 1'h1;
    cyc(3);
    chk("src", SRC_SERIAL, cmd_source);
    serial_valid <= 1'h0;
    cyc(3);
    chk("src", SRC_PULSE, cmd_source);
    pulse_valid <= 1'h0;
    cyc(3);
    chk("src", SRC_NONE, cmd_source);
    wb(1'h1, ADR_PRIO, 32'h0);
    wb(1'h1, ADR_CTRL, 32'h14);
    pulse_valid <= 1'h1;
    cyc(3);
    chk("src", SRC_PULSE, cmd_source);
    wb(1'h1, ADR_CTRL, 32'h24);
    cyc(3);
    chk("src", SRC_NONE, cmd_source);
    pulse_valid <= 1'h0;
  endtask
  // Analog sits in slot 2; start is refused until the input is centred.
  task automatic t_ana;
    analog_mv <= 13'h0064;
    wb(1'h1, ADR_PRIO, 32'h2D);
    cyc(3);
    chk("src", SRC_ANALOG, cmd_source);
    chk("allow", 1'h0, cmd_allow);
    analog_mv <= 13'h0BB8;
    cyc(3);
    chk("allow", 1'h0, cmd_allow);
    analog_mv <= 13'h09C4;
    cyc(3);
    chk("allow", 1'h1, cmd_allow);
    analog_mv <= 13'h0BB8;
    cyc(3);
    chk("allow", 1'h1, cmd_allow);
    serial_valid <= 1'h1;
    cyc(3);
    chk("src", SRC_SERIAL, cmd_source);
    serial_valid <= 1'h0;
    analog_mv <= 13'h1324;
    cyc(3);
    chk("allow", 1'h0, cmd_allow);
    analog_valid <= 1'h0;
  endtask
  task automatic t_pins;
    main_pin <= 8'h96;
    for (int f = 1; f < 4; f++) begin
      wb(1'h1, ADR_PINFN, 32'h5555 * f);
      cyc(4);
      chk("pulse", (f == 1) ? 8'h96 : 8'h00, pulse_in);
      chk("analog", (f == 2) ? 8'hFF : 8'h00, analog_en);
      chk("digital", (f == 3) ? 8'h96 : 8'h00, digital_in);
    end
  endtask
  task automatic t_sto;
    // Pins 2 and 3 give up their digital use while torque-off is on.
    sto_jumper <= 1'h1;
    main_pin <= 8'h0C;
    cyc(5);
    chk("sto", 2'h3, {torque_off_input_a, torque_off_input_b});
    chk("digital", 8'h00, digital_in);
    chk("power", 1'h1, power_enable);
    main_pin <= 8'h04;
    cyc(5);
    chk("power", 1'h0, power_enable);
    main_pin <= 8'h00;
    cyc(5);
    chk("power", 1'h0, power_enable);
    rdchk("stat", ADR_STAT, 32'h08);
    wb(1'h1, ADR_STAT, 32'h08);
    rdchk("stat", ADR_STAT, 32'h00);
    sto_jumper <= 1'h0;
  endtask
  task automatic t_usb;
    usb_present <= 1'h1;
    rs485_tx_active <= 1'h1;
    cyc(5);
    chk("usb", 1'h1, usb_link_ok);
    chk("can", 1'h1, can_enable);
    chk("drv", 1'h0, rs485_drv_oe_n);
    usb_present <= 1'h0;
    rs485_tx_active <= 1'h0;
    cyc(5);
    usb_present <= 1'h1;
    cyc(5);
    chk("usb", 1'h0, usb_link_ok);
  endtask
  task automatic t_ssi;
    q1a <= 1'h1;
    cyc(4);
    chk("phase", 1'h1, encoder_one_phase_a);
    chk("oe", 1'h1, c1_pin4_oe_n);
    w1 <= 16'hA5C3;
    w2 <= 16'h9E17;
    wb(1'h1, ADR_CTRL, 32'h25);
    for (int i = 0; i < 300 && rd !== 32'hA5C3; i++)
      wb(1'h0, ADR_ENC1, 32'h0);
    chk("enc1", 32'hA5C3, rd);
    rdchk("enc2", ADR_ENC2, 32'h9E17);
    chk("oe", 1'h0, c1_pin4_oe_n);
    chk("enc3", 1'h0, encoder_three_phase_a);
    wb(1'h1, ADR_PINFN, 32'h5555);
    wb(1'h1, ADR_CTRL, 32'h27);
    main_pin <= 8'hC0;
    cyc(4);
    chk("phase", 2'h2, {encoder_one_phase_a, encoder_two_phase_a});
    chk("pulse", 8'h00, pulse_in);
    main_pin <= 8'h3F;
    cyc(4);
    chk("phase", 2'h1, {encoder_one_phase_a, encoder_two_phase_a});
    chk("pulse", 8'h0F, pulse_in);
    wb(1'h1, ADR_CTRL, 32'h17);
    cyc(4);
    chk("pulse", 8'h3F, pulse_in);
  endtask

  task automatic conclude;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge mclk) begin
    tick++;
    if (tick == 40000) begin
      n_errors++;
      conclude;
    end
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, sto_jumper} = 5'h0;
    {serial_valid, pulse_valid, analog_valid, usb_present} = 4'h0;
    {rs485_tx_active, q1a, q1b, q2a} = 4'h0;
    {wb_adr_i, main_pin, wb_dat_i, wb_sel_i} = 52'hF;
    {analog_mv, w1, w2} = 45'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_reset;
    t_arb;
    t_ana;
    t_pins;
    t_sto;
    t_usb;
    t_ssi;
    conclude;
  end
endmodule
